// ==== rtl/fsw_pkg.sv ====
package fsw_pkg;
    // instruction codes
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
    localparam logic [7:0] OP_WHOLE_ERASE = 8'hC7;

    // status byte field positions
    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL = 1;
    localparam int BIT_BP_LO = 2;
    localparam int BIT_BP_HI = 4;
    localparam int BIT_STATUS_WRITE_DISABLE = 7;

    // values after reset
    localparam logic WEL_RESET = 1'h0;
    localparam logic STATUS_WRITE_DISABLE_RESET = 1'h0;
    localparam logic [2:0] BP_RESET = 3'h0;

    // frame lengths in whole bytes
    localparam logic [2:0] LEN_SHORT = 3'h1;
    localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
    localparam logic [2:0] LEN_SECTOR_ERASE = 3'h4;
    localparam logic [2:0] LEN_PROGRAM_MIN = 3'h5;

    // self-timed cycle durations
    localparam int unsigned CLOCK_PERIOD_NS = 10;
    localparam int unsigned STATUS_WRITE_TIME_NS = 5000000;
    localparam int unsigned PAGE_PROGRAM_TIME_NS = 2000000;
    localparam int unsigned SECTOR_ERASE_TIME_NS = 1000000000;
    localparam int unsigned WHOLE_ERASE_TIME_NS = 2000000000;
    localparam int unsigned STATUS_WRITE_CYCLES_DEF =
        (STATUS_WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned PAGE_PROGRAM_CYCLES_DEF =
        (PAGE_PROGRAM_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned SECTOR_ERASE_CYCLES_DEF =
        (SECTOR_ERASE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned WHOLE_ERASE_CYCLES_DEF =
        (WHOLE_ERASE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // lowest protected sector (address bits 23:16) per block-protect code
    localparam logic [7:0][7:0] PROTECT_FLOOR_DEF =
        {8'h00, 8'h00, 8'h40, 8'h60, 8'h70, 8'h78, 8'h7C, 8'hFF};

    typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_ARGS, ST_READ, ST_IGNORE} fsw_frame_t;
    typedef enum logic {CYC_STATUS, CYC_ARRAY} fsw_cycle_t;
endpackage : fsw_pkg

// ==== rtl/fsw_if.sv ====
interface fsw_link_if;
    logic frame_start;
    logic frame_end;
    logic frame_aligned;
    logic sclk_fall;
    logic byte_valid;
    logic [7:0] byte_data;
    logic [2:0] byte_index;
    logic [2:0] byte_count;
    modport rx (output frame_start, frame_end, frame_aligned, sclk_fall, byte_valid,
                byte_data, byte_index, byte_count);
    modport user (input frame_start, frame_end, frame_aligned, sclk_fall, byte_valid,
                  byte_data, byte_index, byte_count);
endinterface : fsw_link_if

interface fsw_timer_if;
    logic start;
    logic [31:0] cycles;
    logic busy;
    logic done;
    modport timer (input start, cycles, output busy, done);
    modport user (output start, cycles, input busy, done);
endinterface : fsw_timer_if

// ==== rtl/fsw_spi_rx.sv ====
module fsw_spi_rx (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic spi_clk_in,
    input wire logic chip_sel_n_in,
    input wire logic spi_data_in,
    fsw_link_if.rx link
);
    // [0] first flop, [1] second flop, [2] edge history
    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [1:0] d_s;
    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic [2:0] idx;
    logic sck_rise;
    logic sck_fall;
    logic cs_low;

    assign sck_rise = sck_s[1] & ~sck_s[2];
    assign sck_fall = ~sck_s[1] & sck_s[2];
    assign cs_low = ~cs_s[1];
    assign link.byte_count = idx;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_s <= 3'h0;
            cs_s <= 3'h7;
            d_s <= 2'h0;
        end else begin
            sck_s <= {sck_s[1:0], spi_clk_in};
            cs_s <= {cs_s[1:0], chip_sel_n_in};
            d_s <= {d_s[0], spi_data_in};
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link.frame_start <= 1'h0;
            link.frame_end <= 1'h0;
            link.frame_aligned <= 1'h0;
            link.sclk_fall <= 1'h0;
        end else begin
            link.frame_start <= ~cs_s[1] & cs_s[2];
            link.frame_end <= cs_s[1] & ~cs_s[2];
            link.frame_aligned <= cs_s[1] & ~cs_s[2] & (bit_cnt == 3'h0);
            link.sclk_fall <= sck_fall & cs_low;
        end
    end

    // msb first, sampled on serial clock rising edges
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_cnt <= 3'h0;
            shift <= 7'h00;
            idx <= 3'h0;
            link.byte_valid <= 1'h0;
            link.byte_data <= 8'h00;
            link.byte_index <= 3'h0;
        end else begin
            link.byte_valid <= 1'h0;
            if (~cs_s[1] & cs_s[2]) begin
                bit_cnt <= 3'h0;
                idx <= 3'h0;
            end else if (sck_rise && cs_low) begin
                shift <= {shift[5:0], d_s[1]};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    link.byte_valid <= 1'h1;
                    link.byte_data <= {shift, d_s[1]};
                    link.byte_index <= idx;
                    // saturates: long program frames only need "five or more"
                    if (idx != 3'h7) begin
                        idx <= idx + 3'h1;
                    end
                end
            end
        end
    end
endmodule : fsw_spi_rx

// ==== rtl/fsw_cycle_timer.sv ====
module fsw_cycle_timer (
    input wire logic clock_in,
    input wire logic rst_n_in,
    fsw_timer_if.timer tmr
);
    logic [31:0] count;

    // start is ignored while a cycle runs
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= 32'h0;
            tmr.busy <= 1'h0;
            tmr.done <= 1'h0;
        end else begin
            tmr.done <= 1'h0;
            if (tmr.busy) begin
                if (count == 32'h0) begin
                    tmr.busy <= 1'h0;
                    tmr.done <= 1'h1;
                end else begin
                    count <= count - 32'h1;
                end
            end else if (tmr.start) begin
                tmr.busy <= 1'h1;
                count <= tmr.cycles - 32'h1;
            end
        end
    end
endmodule : fsw_cycle_timer

// ==== rtl/fsw_status_protect.sv ====
// Contract
// - busy flag is 1 during status-write, program or erase cycle, else 0
// - with write-enable latch clear, status-write, program and erase are refused
// - block-protect bits are non-volatile, written only by status-write; reset here loads BP_RESET (zero)
// - whole-array erase runs only when all block-protect bits are zero
// - protect disable set and protect pin low: hardware mode, status writes refused
// - a completed write-enable instruction sets the write-enable latch
// - status-write leaves b6, b5, b1, b0; b6 and b5 read zero
// - select must rise right after the data byte, else status-write is dropped
// - valid status-write starts a self-timed cycle, busy set, status readable
// - end of the status-write cycle clears the write-enable latch
// - protect disable clear: status writes accepted with latch set, any pin level
// - protect disable set and pin high: status writes accepted with latch set
// - hardware mode entered by whichever comes last: bit set or pin low
// - hardware mode left only by the protect pin returning high
// - latch cleared at reset and after disable, status-write, program, erases
// - status register readable at any time, also during self-timed cycles
module fsw_status_protect
    import fsw_pkg::*;
#(
    parameter int unsigned STATUS_WRITE_CYCLES = STATUS_WRITE_CYCLES_DEF,
    parameter int unsigned PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_CYCLES_DEF,
    parameter int unsigned SECTOR_ERASE_CYCLES = SECTOR_ERASE_CYCLES_DEF,
    parameter int unsigned WHOLE_ERASE_CYCLES = WHOLE_ERASE_CYCLES_DEF,
    parameter logic [7:0][7:0] PROTECT_FLOOR = PROTECT_FLOOR_DEF
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic spi_clk_in,
    input wire logic chip_sel_n_in,
    input wire logic spi_data_in,
    input wire logic write_protect_n_in,
    output logic spi_data_out,
    output logic spi_data_oe_n_out,
    output logic [7:0] status_out,
    output logic hw_protected_out
);
    logic [1:0] rst_pipe;
    logic rst_n;
    logic [1:0] wp_s;
    logic hardware_protected_mode;
    fsw_frame_t state;
    fsw_cycle_t cyc_kind;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] wr_data;
    logic write_enable_latch;
    logic status_write_disable;
    logic [2:0] bp;
    logic pend_status_write_disable;
    logic [2:0] pend_bp;
    logic [7:0] status_byte;
    logic [7:0] snap;
    logic [2:0] out_ptr;
    logic addr_prot;
    logic cmd_ok;
    logic go_write_enable_cmd;
    logic go_write_disable_cmd;
    logic go_status_write_cmd;
    logic go_pp;
    logic go_se;
    logic go_be;

    fsw_link_if link ();
    fsw_timer_if tmr ();

    fsw_spi_rx u_rx (
        .clock_in(clock_in),
        .rst_n_in(rst_n),
        .spi_clk_in(spi_clk_in),
        .chip_sel_n_in(chip_sel_n_in),
        .spi_data_in(spi_data_in),
        .link(link.rx)
    );

    fsw_cycle_timer u_timer (
        .clock_in(clock_in),
        .rst_n_in(rst_n),
        .tmr(tmr.timer)
    );

    // reset released through two flops
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'h1};
        end
    end
    assign rst_n = rst_pipe[1];

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            wp_s <= 2'h3;
        end else begin
            wp_s <= {wp_s[0], write_protect_n_in};
        end
    end

    // no instruction can clear this; only the pin going high ends it
    assign hardware_protected_mode = status_write_disable & ~wp_s[1];

    always_comb begin
        status_byte = 8'h00;
        status_byte[BIT_BUSY] = tmr.busy;
        status_byte[BIT_WEL] = write_enable_latch;
        status_byte[BIT_BP_HI:BIT_BP_LO] = bp;
        status_byte[BIT_STATUS_WRITE_DISABLE] = status_write_disable;
    end

    // range table is a parameter so each density can supply its own
    assign addr_prot = (bp != 3'h0) && (addr[23:16] >= PROTECT_FLOOR[bp]);

    // only whole-byte frames count, and nothing but a status read runs while a cycle is busy
    assign cmd_ok = link.frame_end && link.frame_aligned && (state == ST_ARGS)
                    && !tmr.busy;
    assign go_write_enable_cmd = cmd_ok && (opcode == OP_WRITE_ENABLE)
                     && (link.byte_count == LEN_SHORT);
    assign go_write_disable_cmd = cmd_ok && (opcode == OP_WRITE_DISABLE)
                     && (link.byte_count == LEN_SHORT);
    assign go_status_write_cmd = cmd_ok && (opcode == OP_STATUS_WRITE) && write_enable_latch && !hardware_protected_mode
                     && (link.byte_count == LEN_STATUS_WRITE);
    assign go_pp = cmd_ok && (opcode == OP_PAGE_PROGRAM) && write_enable_latch && !addr_prot
                   && (link.byte_count >= LEN_PROGRAM_MIN);
    assign go_se = cmd_ok && (opcode == OP_SECTOR_ERASE) && write_enable_latch && !addr_prot
                   && (link.byte_count == LEN_SECTOR_ERASE);
    assign go_be = cmd_ok && (opcode == OP_WHOLE_ERASE) && write_enable_latch && (bp == 3'h0)
                   && (link.byte_count == LEN_SHORT);

    assign tmr.start = go_status_write_cmd | go_pp | go_se | go_be;

    always_comb begin
        if (go_status_write_cmd) begin
            tmr.cycles = 32'(STATUS_WRITE_CYCLES);
        end else if (go_pp) begin
            tmr.cycles = 32'(PAGE_PROGRAM_CYCLES);
        end else if (go_se) begin
            tmr.cycles = 32'(SECTOR_ERASE_CYCLES);
        end else begin
            tmr.cycles = 32'(WHOLE_ERASE_CYCLES);
        end
    end

    // frame sequencing
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            opcode <= 8'h00;
            addr <= 24'h000000;
            wr_data <= 8'h00;
        end else if (link.frame_end) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (link.frame_start) begin
                        state <= ST_OPCODE;
                    end
                end
                ST_OPCODE: begin
                    if (link.byte_valid) begin
                        opcode <= link.byte_data;
                        if (link.byte_data == OP_STATUS_READ) begin
                            state <= ST_READ;
                        end else if (tmr.busy) begin
                            state <= ST_IGNORE;
                        end else begin
                            state <= ST_ARGS;
                        end
                    end
                end
                ST_ARGS: begin
                    if (link.byte_valid && (link.byte_index <= 3'h3)) begin
                        addr <= {addr[15:0], link.byte_data};
                        if (link.byte_index == 3'h1) begin
                            wr_data <= link.byte_data;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // latch: a new write-enable beats a completion in the same cycle
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            write_enable_latch <= WEL_RESET;
        end else if (go_write_enable_cmd) begin
            write_enable_latch <= 1'h1;
        end else if (go_write_disable_cmd || tmr.done) begin
            write_enable_latch <= 1'h0;
        end
    end

    // new bits take effect when the timed cycle completes
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            status_write_disable <= STATUS_WRITE_DISABLE_RESET;
            bp <= BP_RESET;
            pend_status_write_disable <= STATUS_WRITE_DISABLE_RESET;
            pend_bp <= BP_RESET;
            cyc_kind <= CYC_STATUS;
        end else begin
            if (tmr.start) begin
                cyc_kind <= go_status_write_cmd ? CYC_STATUS : CYC_ARRAY;
            end
            if (go_status_write_cmd) begin
                pend_status_write_disable <= wr_data[BIT_STATUS_WRITE_DISABLE];
                pend_bp <= wr_data[BIT_BP_HI:BIT_BP_LO];
            end
            if (tmr.done && (cyc_kind == CYC_STATUS) && !hardware_protected_mode) begin
                status_write_disable <= pend_status_write_disable;
                bp <= pend_bp;
            end
        end
    end

    // status shifted out on serial clock falling edges, byte repeats live
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            spi_data_out <= 1'h0;
            spi_data_oe_n_out <= 1'h1;
            snap <= 8'h00;
            out_ptr <= 3'h0;
        end else if (state != ST_READ || link.frame_end) begin
            spi_data_oe_n_out <= 1'h1;
            out_ptr <= 3'h0;
        end else if (link.sclk_fall) begin
            spi_data_oe_n_out <= 1'h0;
            out_ptr <= out_ptr + 3'h1;
            if (out_ptr == 3'h0) begin
                snap <= status_byte;
                spi_data_out <= status_byte[7];
            end else begin
                spi_data_out <= snap[3'h7 - out_ptr];
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            status_out <= 8'h00;
            hw_protected_out <= 1'h0;
        end else begin
            status_out <= status_byte;
            hw_protected_out <= hardware_protected_mode;
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n);

    property p_busy_flag;
        tmr.start |=> status_byte[BIT_BUSY] ##1 status_out[BIT_BUSY];
    endproperty
    a_busy_flag: assert property (p_busy_flag)
        else $error("busy flag not raised after cycle start");

    property p_refuse_no_wel;
        (link.frame_end && !write_enable_latch && !tmr.busy) |=> !tmr.busy;
    endproperty
    a_refuse_no_wel: assert property (p_refuse_no_wel)
        else $error("write started with latch clear");

    property p_nv_hold;
        !(tmr.done && (cyc_kind == CYC_STATUS)) |=> $stable({status_write_disable, bp});
    endproperty
    a_nv_hold: assert property (p_nv_hold)
        else $error("protect bits changed outside status-write completion");

    property p_whole_erase_bp;
        (cmd_ok && (opcode == OP_WHOLE_ERASE) && (bp != 3'h0)) |=> !tmr.busy;
    endproperty
    a_whole_erase_bp: assert property (p_whole_erase_bp)
        else $error("whole erase ran with protect bits set");

    property p_hpm_refuse;
        (cmd_ok && hardware_protected_mode && (opcode == OP_STATUS_WRITE)) |=> !tmr.busy;
    endproperty
    a_hpm_refuse: assert property (p_hpm_refuse)
        else $error("status write accepted in hardware mode");

    property p_write_enable_cmd_sets;
        go_write_enable_cmd |=> write_enable_latch ##1 status_out[BIT_WEL];
    endproperty
    a_write_enable_cmd_sets: assert property (p_write_enable_cmd_sets)
        else $error("write enable did not set latch");

    property p_zero_bits;
        (status_out[6:5] == 2'h0) && (status_byte[6:5] == 2'h0);
    endproperty
    a_zero_bits: assert property (p_zero_bits)
        else $error("bits 6 and 5 not zero");

    property p_misaligned;
        (link.frame_end && !link.frame_aligned && !tmr.busy) |=> !tmr.busy;
    endproperty
    a_misaligned: assert property (p_misaligned)
        else $error("instruction ran after misaligned select rise");

    property p_status_write_cmd_cycle;
        go_status_write_cmd |=> (tmr.busy && (cyc_kind == CYC_STATUS));
    endproperty
    a_status_write_cmd_cycle: assert property (p_status_write_cmd_cycle)
        else $error("status write cycle did not start");

    property p_done_clears;
        (tmr.done && !go_write_enable_cmd) |=> !write_enable_latch;
    endproperty
    a_done_clears: assert property (p_done_clears)
        else $error("latch still set after cycle end");

    property p_hpm_exit;
        $fell(hardware_protected_mode) |-> (wp_s[1] && status_write_disable);
    endproperty
    a_hpm_exit: assert property (p_hpm_exit)
        else $error("hardware mode left with pin low");

    property p_protect;
        (cmd_ok && addr_prot && (opcode == OP_PAGE_PROGRAM)) |=> !tmr.busy;
    endproperty
    a_protect: assert property (p_protect)
        else $error("program into protected region");

    property p_write_disable_cmd_clears;
        go_write_disable_cmd |=> !write_enable_latch;
    endproperty
    a_write_disable_cmd_clears: assert property (p_write_disable_cmd_clears)
        else $error("write disable left latch set");

    c_status_write: cover property (go_status_write_cmd);
    c_page_program: cover property (go_pp);
    c_enter_hpm: cover property ($rose(hardware_protected_mode));
    c_status_read: cover property ((state == ST_READ) && link.sclk_fall);
endmodule : fsw_status_protect

// ==== sim/fsw_host_model.sv ====
module fsw_host_model (
    input wire logic clock_in,
    input wire logic miso_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out,
    output logic rd_done_out,
    output logic [7:0] rd_byte_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
        rd_done_out = 1'b0;
        rd_byte_out = 8'h00;
    end

    // 8 system clocks per half period gives the 160 ns serial clock
    task automatic half();
        repeat (8) @(posedge clock_in);
    endtask : half

    // data set while clock low, both ends sample at the rise, msb first
    task automatic put_bits(input logic [7:0] b, input int n, inout logic [7:0] r);
        for (int i = 7; i > 7 - n; i--) begin
            mosi_out <= b[i];
            half();
            sclk_out <= 1'b1;
            r[i] = miso_in;
            half();
            sclk_out <= 1'b0;
        end
    endtask : put_bits

    // whole bytes then optional stray bits; clock stands low outside frames
    task automatic frame(input logic [39:0] w, input int nb, input int tail, input bit rd);
        logic [7:0] r;
        r = 8'h00;
        @(posedge clock_in);
        cs_n_out <= 1'b0;
        half();
        for (int k = 0; k < nb; k++) begin
            put_bits(w[39 - 8 * k -: 8], 8, r);
        end
        if (tail > 0) begin
            put_bits(8'h00, tail, r);
        end
        half();
        cs_n_out <= 1'b1;
        mosi_out <= ~mosi_out;
        if (rd) begin
            rd_byte_out <= r;
            rd_done_out <= 1'b1;
        end
        @(posedge clock_in);
        rd_done_out <= 1'b0;
        repeat (10) @(posedge clock_in);
    endtask : frame
endmodule : fsw_host_model

// ==== sim/flash_status_write_protect_test.sv ====
module flash_status_write_protect_test import fsw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock_in = 1'b0;
    logic reset_n_in;
    logic wp_n;
    wire logic spi_clk, chip_sel_n, spi_mosi, spi_miso, rd_done;
    wire logic spi_data, spi_data_oe_n, hw_prot;
    wire logic [7:0] status, rd_byte;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 32'h73C3F2BA;
    logic [15:0] exp_q[$];
    logic [7:0] d;
    logic [7:0] p = 8'h00;
    logic [39:0] ops [5] = '{{OP_WHOLE_ERASE, 32'h0}, {OP_PAGE_PROGRAM, 32'h7C0000A5},
        {OP_SECTOR_ERASE, 32'h7D000000}, {OP_PAGE_PROGRAM, 32'h000000A5},
        {OP_SECTOR_ERASE, 32'h7B000000}};
    int lens [5] = '{1, 5, 4, 5, 4};
    logic [0:4] acc = 5'b00011;

    always #5 clock_in = ~clock_in;

    // released line shows the inverse, so a late or missing enable is caught
    assign spi_miso = spi_data_oe_n ? ~spi_data : spi_data;

    fsw_status_protect #(
        .STATUS_WRITE_CYCLES(600),
        .PAGE_PROGRAM_CYCLES(600),
        .SECTOR_ERASE_CYCLES(700),
        .WHOLE_ERASE_CYCLES(800)
    ) i_fsw_status_protect (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .spi_clk_in(spi_clk),
        .chip_sel_n_in(chip_sel_n),
        .spi_data_in(spi_mosi),
        .write_protect_n_in(wp_n),
        .spi_data_out(spi_data),
        .spi_data_oe_n_out(spi_data_oe_n),
        .status_out(status),
        .hw_protected_out(hw_prot)
    );

    fsw_host_model i_fsw_host_model (
        .clock_in(clock_in),
        .miso_in(spi_miso),
        .sclk_out(spi_clk),
        .cs_n_out(chip_sel_n),
        .mosi_out(spi_mosi),
        .rd_done_out(rd_done),
        .rd_byte_out(rd_byte)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic cmd(input logic [39:0] w, input int nb);
        i_fsw_host_model.frame(w, nb, 0, 1'b0);
    endtask : cmd

    // note the masked expectation, then read one status byte
    task automatic rd(input logic [7:0] m, input logic [7:0] e);
        exp_q.push_back({m, e & m});
        i_fsw_host_model.frame({OP_STATUS_READ, 32'h0}, 2, 0, 1'b1);
    endtask : rd

    task automatic wr_status(input logic [7:0] v, input int tail);
        cmd({OP_WRITE_ENABLE, 32'h0}, 1);
        i_fsw_host_model.frame({OP_STATUS_WRITE, v, 24'h0}, 2, tail, 1'b0);
    endtask : wr_status

    task automatic wait_idle();
        int n;
        n = 0;
        while (status[0] !== 1'b0 && n < 3000) begin
            @(posedge clock_in);
            n++;
        end
        if (n >= 3000) begin
            num_errors++;
            $display("mismatch at %0t: busy never cleared", $time);
        end
    endtask : wait_idle

    always @(posedge rd_done) begin : mon
        logic [15:0] e;
        e = exp_q.pop_front();
        check(rd_byte & e[15:8], e[7:0]);
    end

    task automatic hw_is(input logic v);
        repeat (6) @(posedge clock_in);
        check({7'h0, hw_prot}, {7'h0, v});
    endtask : hw_is

    initial begin
        reset_n_in = 1'b0;
        wp_n = 1'b1;
        repeat (4) @(posedge clock_in);
        reset_n_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        rd(8'hFF, 8'h00);
        cmd({OP_STATUS_WRITE, 8'h9C, 24'h0}, 2);
        rd(8'hFF, 8'h00);
        cmd({OP_WRITE_ENABLE, 32'h0}, 1);
        rd(8'hFF, 8'h02);
        cmd({OP_WRITE_DISABLE, 32'h0}, 1);
        rd(8'hFF, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 8'hFF : 8'($random(seed));
            wr_status(d, 0);
            rd(8'hFF, {p[7], 2'b00, p[4:2], 2'b11});
            wait_idle();
            rd(8'hFF, {d[7], 2'b00, d[4:2], 2'b00});
            p = d;
        end
        // block-protect code 1: lowest protected sector 7C
        wr_status(8'h84, 0);
        wait_idle();
        for (int i = 0; i < 5; i++) begin
            cmd({OP_WRITE_ENABLE, 32'h0}, 1);
            cmd(ops[i], lens[i]);
            rd(8'h01, {7'h0, acc[i]});
            wait_idle();
        end
        rd(8'hFF, 8'h84);
        check(status, 8'h84);
        wp_n <= 1'b0;
        hw_is(1'b1);
        wr_status(8'h00, 0);
        rd(8'hFF, 8'h86);
        wp_n <= 1'b1;
        hw_is(1'b0);
        wr_status(8'h00, 0);
        wait_idle();
        rd(8'hFF, 8'h00);
        wp_n <= 1'b0;
        hw_is(1'b0);
        wr_status(8'h80, 0);
        wait_idle();
        rd(8'hFF, 8'h80);
        hw_is(1'b1);
        wp_n <= 1'b1;
        hw_is(1'b0);
        // select rising three bits past the data byte drops the write
        wr_status(8'h1C, 3);
        rd(8'hFF, 8'h82);
        end_sim();
    end

    initial begin
        repeat (60000) @(posedge clock_in);
        num_errors++;
        end_sim();
    end
endmodule : flash_status_write_protect_test
